// *** logic/pps_regs_defs.svh ***
`ifndef PPS_REGS_DEFS_SVH
`define PPS_REGS_DEFS_SVH

// ============================================================
// address layout: byte address = global * 256 + port * 64 + index * 4
`define PPS_ADDR_IDX_HI     5
`define PPS_ADDR_IDX_LO     2
`define PPS_ADDR_PORT_HI    7
`define PPS_ADDR_PORT_LO    6
`define PPS_ADDR_GLOBAL     8

// ============================================================
// per-port register indices
`define PPS_IDX_FUNC        4'h2
`define PPS_IDX_CTRL2       4'h3
`define PPS_IDX_STAT1       4'h4
`define PPS_IDX_STAT2       4'h5
`define PPS_IDX_DISC_LO     4'h6
`define PPS_IDX_DISC_HI     4'h7

// ============================================================
// global page register indices
`define PPS_IDX_IRQ_STATUS  4'h0
`define PPS_IDX_IRQ_MASK    4'h1

// ============================================================
// field positions
`define PPS_CTRL2_DISABLE   4
`define PPS_CTRL2_START     3
`define PPS_CTRL2_ABORT     2
`define PPS_STAT1_FAIL      7
`define PPS_STAT1_DONE      6
`define PPS_STAT2_WDOG      4
`define PPS_STAT2_BUSY      3
`define PPS_DISC_HI_CMPL    7

// ============================================================
// function codes and reset values
`define PPS_FN_OFF          4'h0
`define PPS_FN_DISC1        4'h1
`define PPS_FN_DISC2        4'h2
`define PPS_RST_BYTE        8'h00
`define PPS_RST_WORD        32'h0000_0000
`define PPS_RST_RESULT      15'h0000

`endif

// *** logic/pps_regs_pkg.sv ***
package pps_regs_pkg;

    // port engine status toward the register bank
    typedef struct packed {
        logic        discFail;
        logic        funcDone;
        logic [2:0]  powerClass;
        logic [2:0]  faultCause;
        logic        wdogActive;
        logic [2:0]  portState;
        logic        adcDone;
        logic [14:0] adcResult;
    } pps_engine_t;

    // per-port command and register state
    typedef struct packed {
        logic [3:0]  func;
        logic        funcWr;
        logic        portOff;
        logic        start;
        logic        abort;
        logic        busy;
        logic        done;
        logic        discCmpl;
        logic [14:0] discResult;
    } pps_port_t;

    typedef struct packed {
        pps_port_t [3:0] port;
        logic [7:0]      irqStatus;
        logic [7:0]      irqMask;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
        logic            irq;
    } pps_state_t;

endpackage : pps_regs_pkg

// *** logic/pps_port_regs.sv ***
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "pps_regs_defs.svh"

module pps_port_regs
    import pps_regs_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int PORTS  = 4
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // port engines
    input  wire pps_engine_t [PORTS-1:0] engine,
    // commands to the port engines
    output logic [PORTS-1:0][3:0]     funcCode,
    output logic [PORTS-1:0]          funcWrite,
    output logic [PORTS-1:0]          portDisable,
    output logic [PORTS-1:0]          adcStart,
    output logic [PORTS-1:0]          adcAbort,
    // interrupt
    output logic                      irq
);

    pps_state_t s_q;
    pps_state_t s_d;

    // ========================================================
    // address decode
    function automatic logic addrBad(input logic [ADDR_W-1:0] a);
        logic [3:0] idx;
        idx = a[`PPS_ADDR_IDX_HI:`PPS_ADDR_IDX_LO];
        if (a[1:0] != 2'b00 || (ADDR_W > `PPS_ADDR_GLOBAL + 1 &&
            a[ADDR_W-1:`PPS_ADDR_GLOBAL+1] != '0)) begin
            return 1'b1;
        end
        if (a[`PPS_ADDR_GLOBAL]) begin
            return a[`PPS_ADDR_PORT_HI:`PPS_ADDR_PORT_LO] != 2'b00 ||
                   idx > `PPS_IDX_IRQ_MASK;
        end
        return idx < `PPS_IDX_FUNC || idx > `PPS_IDX_DISC_HI;
    endfunction : addrBad

    function automatic logic isDiscovery(input logic [3:0] f);
        return f == `PPS_FN_DISC1 || f == `PPS_FN_DISC2;
    endfunction : isDiscovery

    // ========================================================
    // read data
    function automatic logic [7:0] readByte(
        input logic [3:0]  idx,
        input pps_port_t   p,
        input pps_engine_t e
    );
        logic [7:0] b;
        b = `PPS_RST_BYTE;
        case (idx)
            `PPS_IDX_FUNC: begin
                b[3:0] = p.func;
            end
            `PPS_IDX_CTRL2: begin
                b[`PPS_CTRL2_DISABLE] = p.portOff;
                b[`PPS_CTRL2_START]   = p.start;
                b[`PPS_CTRL2_ABORT]   = p.abort;
            end
            `PPS_IDX_STAT1: begin
                b[`PPS_STAT1_FAIL] = e.discFail;
                b[`PPS_STAT1_DONE] = p.done;
                b[5:3]             = e.powerClass;
                b[2:0]             = e.faultCause;
            end
            `PPS_IDX_STAT2: begin
                b[`PPS_STAT2_WDOG] = e.wdogActive;
                b[`PPS_STAT2_BUSY] = p.busy;
                b[2:0]             = e.portState;
            end
            `PPS_IDX_DISC_LO: begin
                b = p.discResult[7:0];
            end
            `PPS_IDX_DISC_HI: begin
                b[6:0]               = p.discResult[14:8];
                b[`PPS_DISC_HI_CMPL] = p.discCmpl;
            end
            default: begin
                b = `PPS_RST_BYTE;
            end
        endcase
        return b;
    endfunction : readByte

    // ========================================================
    // next state
    logic [3:0] aIdx;
    logic [1:0] aPort;
    logic       aGlobal;
    logic       access;
    logic       wrNow;
    logic [7:0] evt;
    logic [7:0] w1c;

    assign aIdx    = paddr[`PPS_ADDR_IDX_HI:`PPS_ADDR_IDX_LO];
    assign aPort   = paddr[`PPS_ADDR_PORT_HI:`PPS_ADDR_PORT_LO];
    assign aGlobal = paddr[`PPS_ADDR_GLOBAL];
    assign access  = psel & penable;
    // write lands at the edge where pready is seen high
    assign wrNow   = access & s_q.pready & pwrite & ~s_q.pslverr
                     & pstrb[0];

    always_comb begin
        s_d = s_q;
        evt = 8'h00;
        w1c = 8'h00;

        // bus answer: one wait state, then pready for one cycle
        if (access && !s_q.pready) begin
            s_d.pready  = 1'b1;
            s_d.pslverr = addrBad(paddr);
            s_d.prdata  = `PPS_RST_WORD;
            if (!addrBad(paddr) && !pwrite) begin
                if (aGlobal) begin
                    s_d.prdata[7:0] = (aIdx == `PPS_IDX_IRQ_STATUS) ?
                                      s_q.irqStatus : s_q.irqMask;
                end else begin
                    s_d.prdata[7:0] = readByte(aIdx, s_q.port[aPort],
                                               engine[aPort]);
                end
            end
        end else begin
            s_d.pready  = 1'b0;
            s_d.pslverr = 1'b0;
        end

        for (int p = 0; p < PORTS; p++) begin
            s_d.port[p].funcWr = 1'b0;
            s_d.port[p].start  = 1'b0;
            // conversion ends on completion or abort
            if (engine[p].adcDone || s_q.port[p].abort) begin
                s_d.port[p].busy = 1'b0;
            end
            if (wrNow && !aGlobal && aPort == 2'(p)) begin
                case (aIdx)
                    `PPS_IDX_FUNC: begin
                        s_d.port[p].func   = pwdata[3:0];
                        s_d.port[p].funcWr = 1'b1;
                        s_d.port[p].done   = 1'b0;
                        if (isDiscovery(pwdata[3:0])) begin
                            s_d.port[p].discCmpl = 1'b0;
                            s_d.port[p].busy     = 1'b1;
                        end
                        if (pwdata[3:0] == `PPS_FN_OFF) begin
                            s_d.port[p].busy  = 1'b0;
                            s_d.port[p].abort = 1'b0;
                        end
                    end
                    `PPS_IDX_CTRL2: begin
                        s_d.port[p].portOff =
                            pwdata[`PPS_CTRL2_DISABLE];
                        s_d.port[p].abort =
                            pwdata[`PPS_CTRL2_ABORT];
                        s_d.port[p].start =
                            pwdata[`PPS_CTRL2_START];
                        if (pwdata[`PPS_CTRL2_START] &&
                            !pwdata[`PPS_CTRL2_ABORT]) begin
                            s_d.port[p].busy = 1'b1;
                        end
                    end
                    default: begin
                        s_d.port[p].func = s_d.port[p].func;
                    end
                endcase
            end
            // hardware set wins over the host clear
            if (engine[p].funcDone) begin
                s_d.port[p].done = 1'b1;
                evt[p] = 1'b1;
            end
            if (engine[p].adcDone && isDiscovery(s_q.port[p].func)
                && s_q.port[p].busy) begin
                s_d.port[p].discResult = engine[p].adcResult;
                s_d.port[p].discCmpl   = 1'b1;
                evt[4+p] = 1'b1;
            end
        end

        // interrupt status: write one to clear, event wins
        if (wrNow && aGlobal) begin
            if (aIdx == `PPS_IDX_IRQ_STATUS) begin
                w1c = pwdata[7:0];
            end else begin
                s_d.irqMask = pwdata[7:0];
            end
        end
        s_d.irqStatus = (s_q.irqStatus & ~w1c) | evt;
        s_d.irq       = |(s_d.irqStatus & s_d.irqMask);
    end

    // ========================================================
    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================================
    // outputs
    assign pready  = s_q.pready;
    assign prdata  = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign irq     = s_q.irq;

    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            funcCode[p]    = s_q.port[p].func;
            funcWrite[p]   = s_q.port[p].funcWr;
            portDisable[p] = s_q.port[p].portOff;
            adcStart[p]    = s_q.port[p].start;
            adcAbort[p]    = s_q.port[p].abort;
        end
    end

endmodule : pps_port_regs

// *** verification/pps_port_regs_sva.sv ***
`timescale 1ns/1ps
module pps_port_regs_sva
    import pps_regs_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int PORTS  = 4
) (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    // apb
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_W-1:0]     paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic                  pready,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    // commands
    input wire logic [PORTS-1:0][3:0] funcCode,
    input wire logic [PORTS-1:0]      funcWrite,
    input wire logic [PORTS-1:0]      portDisable,
    input wire logic [PORTS-1:0]      adcStart,
    input wire logic [PORTS-1:0]      adcAbort
);
    logic wrDone;
    assign wrDone = psel && penable && pready && pwrite && pstrb[0];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_start_pulse: assert property (
        wrDone && paddr == 12'h00C && pwdata[3] && !pwdata[2]
        |=> adcStart[0] ##1 !adcStart[0]) else $error("start pulse");
    a_disable_follows: assert property (
        wrDone && paddr == 12'h00C |=> portDisable[0] == $past(pwdata[4]))
        else $error("disable bit");
    a_abort_follows: assert property (
        wrDone && paddr == 12'h00C |=> adcAbort[0] == $past(pwdata[2]))
        else $error("abort bit");
    a_cmd_hold: assert property (
        !wrDone |=> $stable({adcAbort, portDisable, funcCode}))
        else $error("command moved");
    a_func_pulse: assert property (
        wrDone && paddr == 12'h008
        |=> funcWrite[0] && funcCode[0] == $past(pwdata[3:0]))
        else $error("function write");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper data");
    a_port_isolated: assert property (
        wrDone && paddr[7:6] != 2'h0 |=> !adcStart[0] && !funcWrite[0])
        else $error("port crosstalk");
    a_unmapped_err: assert property (
        pready && !paddr[8] && paddr[5:3] == 3'h0 |-> pslverr)
        else $error("unmapped");
endmodule : pps_port_regs_sva

bind pps_port_regs pps_port_regs_sva #(.ADDR_W(ADDR_W), .PORTS(PORTS)) u_sva
    (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
     .prdata, .pslverr, .funcCode, .funcWrite, .portDisable, .adcStart,
     .adcAbort);

// *** verification/pps_engine_model.sv ***
`timescale 1ns/1ps
module pps_engine_model
    import pps_regs_pkg::*;
#(
    parameter logic [14:0] RES = 15'h6A5B
) (
    // clock and reset
    input wire logic             clk,
    input wire logic             rst,
    // commands and static status
    input wire logic [3:0]       funcWrite,
    input wire logic [3:0]       adcStart,
    input wire logic [3:0]       adcAbort,
    input wire logic [3:0][10:0] stat,
    // status toward the bank
    output pps_engine_t [3:0]    engine
);
    logic [3:0][3:0] cnt_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            for (int p = 0; p < 4; p++) begin
                if (adcAbort[p]) begin
                    cnt_q[p] <= 4'h0;
                end else if (funcWrite[p] || adcStart[p]) begin
                    cnt_q[p] <= 4'hF;
                end else if (cnt_q[p] != 4'h0) begin
                    cnt_q[p] <= cnt_q[p] - 4'h1;
                end
            end
        end
    end
    // result shows garbage outside the done pulse
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            engine[p] = {stat[p][10], cnt_q[p] == 4'h1, stat[p][9:0],
                cnt_q[p] == 4'h1,
                cnt_q[p] == 4'h1 ? RES ^ 15'(p) : ~(RES ^ 15'(p))};
        end
    end
endmodule : pps_engine_model

// *** verification/test_pps_port_regs.sv ***
`timescale 1ns/1ps
module test_pps_port_regs import pps_regs_pkg::*;;
    typedef struct packed {
        logic w; logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e;
    } pps_row_t;
    logic              clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]       paddr = 12'h000;
    logic [3:0]        pstrb = 4'hF;
    logic [31:0]       pwdata = 32'h0, prdata, r;
    logic [3:0]        funcWrite, portDisable, adcStart, adcAbort;
    logic [3:0][3:0]   funcCode;
    logic [3:0][10:0]  stat = '0;
    logic              pready, pslverr, irq, e;
    pps_engine_t [3:0] engine;
    int                n_errors = 0, n_compared = 0;
    pps_row_t rows [12] = '{
        '{0, 12'h00C, 8'h00, 8'h00, 0}, '{0, 12'h010, 8'h00, 8'h00, 0},
        '{0, 12'h014, 8'h00, 8'h00, 0}, '{0, 12'h018, 8'h00, 8'h00, 0},
        '{0, 12'h01C, 8'h00, 8'h00, 0}, '{1, 12'h0CC, 8'hFF, 8'h00, 0},
        '{0, 12'h0CC, 8'h00, 8'h14, 0}, '{0, 12'h00C, 8'h00, 8'h00, 0},
        '{1, 12'h0CC, 8'h00, 8'h00, 0}, '{1, 12'h010, 8'hFF, 8'h00, 0},
        '{0, 12'h010, 8'h00, 8'h00, 0}, '{0, 12'h000, 8'h00, 8'h00, 1}};

    pps_port_regs u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pready, .prdata, .pslverr, .engine, .funcCode,
        .funcWrite, .portDisable, .adcStart, .adcAbort, .irq);
    pps_engine_model u_eng (.clk, .rst, .funcWrite, .adcStart, .adcAbort,
        .stat, .engine);

    initial begin
        forever #4 clk = ~clk;
    end
    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, g, x);
        end
    endtask : chk
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 0, r, e);
        chk(r, x);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1, a, {24'h0, d}, r, e);
        @(posedge clk);
    endtask : wr

    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, {24'h0, rows[i].d}, r, e);
            if (!rows[i].w)
                chk(r, {24'h0, rows[i].x});
            chk({31'h0, e}, {31'h0, rows[i].e});
        end
        for (int c = 0; c < 8; c++) begin
            stat[0] <= {c[0], 3'(c % 5), 3'(c), c[1], 3'(c)};
            rd(12'h010, {c[0], 1'b0, 3'(c % 5), 3'(c)});
            rd(12'h014, {3'h0, c[1], 1'b0, 3'(c)});
        end
        wr(12'h048, 8'h01);
        rd(12'h054, 8'h08);
        repeat (16) @(posedge clk);
        rd(12'h058, 8'h5A);
        rd(12'h05C, 8'hEA);
        rd(12'h054, 8'h00);
        rd(12'h050, 8'h40);
        rd(12'h100, 8'h22);
        wr(12'h104, 8'h20);
        @(posedge clk);
        chk(irq, 1);
        wr(12'h100, 8'h22);
        @(posedge clk);
        chk(irq, 0);
        wr(12'h048, 8'h02);
        rd(12'h050, 8'h00);
        apb(0, 12'h05C, 0, r, e);
        chk(r[7], 0);
        wr(12'h048, 8'h00);
        wr(12'h08C, 8'h08);
        rd(12'h094, 8'h08);
        rd(12'h08C, 8'h00);
        wr(12'h08C, 8'h04);
        rd(12'h094, 8'h00);
        chk(adcAbort, 4'h4);
        wr(12'h08C, 8'h10);
        chk(portDisable, 4'h4);
        chk(adcAbort, 4'h0);
        pstrb <= 4'h0;
        wr(12'h08C, 8'h00);
        pstrb <= 4'hF;
        rd(12'h08C, 8'h10);
        wr(12'h00C, 8'h08);
        rd(12'h014, 8'h1F);
        wr(12'h008, 8'h05);
        chk(funcCode, 16'h0005);
        rd(12'h008, 8'h05);
        rst <= 1;
        @(posedge clk);
        chk(portDisable, 4'h0);
        rst <= 0;
        @(posedge clk);
        rd(12'h08C, 8'h00);
        give_verdict();
    end
endmodule : test_pps_port_regs
